/* rtl/rsrt_regs.svh */
// constants of the memory-based tapped shift register
`ifndef RSRT_REGS_SVH
`define RSRT_REGS_SVH

// ==========================================================
// geometry
`define RSRT_WIDTH      8
`define RSRT_TAPS       4
`define RSRT_SPACING    3
`define RSRT_DEPTH      2
`define RSRT_BUS_WIDTH  32
`define RSRT_PTR_W      1
`define RSRT_CNT_W      4

// ==========================================================
// sized values
`define RSRT_PTR_ZERO   1'h0
`define RSRT_PTR_LAST   1'h1
`define RSRT_PTR_STEP   1'h1
`define RSRT_CNT_ZERO   4'h0
`define RSRT_CNT_ONE    4'h1
`define RSRT_CNT_FULL   4'hc
`define RSRT_WORD_ZERO  8'h00

`endif

/* rtl/rsrt_pkg.sv */
// types shared by the tapped shift register files
`include "rsrt_regs.svh"

package rsrt_pkg;

  // ==========================================================
  // power-up fill options
  typedef enum logic {
    RSRT_ZERO_FILL,
    RSRT_UNKNOWN_FILL
  } rsrt_fill_t;

  // ==========================================================
  // one stored word
  typedef logic [`RSRT_WIDTH-1:0] rsrt_word_t;

endpackage : rsrt_pkg

/* rtl/rsrt_buf.sv */
// two-entry buffer for words leaving the chain end
`timescale 1ns/1ps
`default_nettype none
`include "rsrt_regs.svh"

module rsrt_buf (
  input  wire logic                 clk_in,
  input  wire logic                 rst_b_in,
  input  wire logic                 in_valid_in,
  input  wire rsrt_pkg::rsrt_word_t in_word_in,
  output logic                      in_ready_out,
  output logic                      out_valid_out,
  output rsrt_pkg::rsrt_word_t      out_word_out,
  input  wire logic                 out_ready_in
);

  // ==========================================================
  // storage
  rsrt_pkg::rsrt_word_t d0_reg, d0_next, d1_reg, d1_next;
  logic                 v0_reg, v0_next, v1_reg, v1_next;
  logic                 rdy_reg, rdy_next;

  // pop first, then push into the lowest free entry
  always_comb begin
    d0_next = d0_reg;
    d1_next = d1_reg;
    v0_next = v0_reg;
    v1_next = v1_reg;
    if (v0_reg && out_ready_in) begin
      d0_next = d1_reg;
      v0_next = v1_reg;
      v1_next = 1'b0;
    end
    if (in_valid_in && rdy_reg) begin
      if (!v0_next) begin
        d0_next = in_word_in;
        v0_next = 1'b1;
      end else begin
        d1_next = in_word_in;
        v1_next = 1'b1;
      end
    end
    rdy_next = !v1_next; // ready while a slot stays free
  end

  // register state
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      d0_reg  <= `RSRT_WORD_ZERO;
      d1_reg  <= `RSRT_WORD_ZERO;
      v0_reg  <= 1'b0;
      v1_reg  <= 1'b0;
      rdy_reg <= 1'b1;
    end else begin
      d0_reg  <= d0_next;
      d1_reg  <= d1_next;
      v0_reg  <= v0_next;
      v1_reg  <= v1_next;
      rdy_reg <= rdy_next;
    end
  end

  assign in_ready_out  = rdy_reg;
  assign out_valid_out = v0_reg;
  assign out_word_out  = d0_reg;

endmodule : rsrt_buf

`default_nettype wire

/* rtl/rsrt_top.sv */
// memory-based shift register with evenly spaced taps
`timescale 1ns/1ps
`default_nettype none
`include "rsrt_regs.svh"

module rsrt_top #(
  parameter rsrt_pkg::rsrt_fill_t FILL_MODE = rsrt_pkg::RSRT_ZERO_FILL
) (
  input  wire logic                        clk_in,
  input  wire logic                        rst_b_in,
  input  wire logic                        clear_in,
  input  wire logic                        shift_en_in,
  input  wire rsrt_pkg::rsrt_word_t        shift_word_in,
  output rsrt_pkg::rsrt_word_t             first_tap_word_out,
  output rsrt_pkg::rsrt_word_t             second_tap_word_out,
  output rsrt_pkg::rsrt_word_t             third_tap_word_out,
  output rsrt_pkg::rsrt_word_t             fourth_tap_word_out,
  output rsrt_pkg::rsrt_word_t             chain_end_out,
  output logic [`RSRT_BUS_WIDTH-1:0]       tap_bus_out,
  output logic                             shift_ready_out,
  output logic                             drain_valid_out,
  output rsrt_pkg::rsrt_word_t             drain_word_out,
  input  wire logic                        drain_ready_in
);

  // ==========================================================
  // reset and clear
  logic ctl_rst_b;  // pointer and fill count
  logic mem_rst_b;  // stored words and tap words
  logic buf_ready;
  logic shift_go;
  logic push_valid;

  // clear always empties; power-up empties only with zero fill
  assign ctl_rst_b = rst_b_in & ~clear_in;
  generate
    if (FILL_MODE == rsrt_pkg::RSRT_ZERO_FILL) begin : g_zero
      assign mem_rst_b = rst_b_in & ~clear_in;
    end else begin : g_unknown
      assign mem_rst_b = ~clear_in;
    end
  endgenerate

  // a shift needs the gate and room for the displaced word
  assign shift_go = shift_en_in & buf_ready;

  // ==========================================================
  // shared circular address
  logic [`RSRT_PTR_W-1:0] ptr_reg, ptr_next;
  logic [`RSRT_CNT_W-1:0] cnt_reg, cnt_next;

  // advance address on each shift, fill count only until it reaches full
  always_comb begin
    ptr_next = ptr_reg;
    cnt_next = cnt_reg;
    if (shift_go) begin
      if (ptr_reg == `RSRT_PTR_LAST) begin
        ptr_next = `RSRT_PTR_ZERO;
      end else begin
        ptr_next = ptr_reg + `RSRT_PTR_STEP;
      end
      if (cnt_reg != `RSRT_CNT_FULL) begin
        cnt_next = cnt_reg + `RSRT_CNT_ONE;
      end
    end
  end

  // register address and count
  always_ff @(posedge clk_in or negedge ctl_rst_b) begin
    if (!ctl_rst_b) begin
      ptr_reg <= `RSRT_PTR_ZERO;
      cnt_reg <= `RSRT_CNT_ZERO;
    end else begin
      ptr_reg <= ptr_next;
      cnt_reg <= cnt_next;
    end
  end

  // a word leaves the chain once every position holds a real one
  assign push_valid = shift_go & (cnt_reg == `RSRT_CNT_FULL);

  // ==========================================================
  // tap segments: spacing-1 memory words plus one tap word
  genvar k;
  generate
    for (k = 0; k < `RSRT_TAPS; k++) begin : g_seg
      rsrt_pkg::rsrt_word_t mem_reg  [`RSRT_DEPTH];
      rsrt_pkg::rsrt_word_t mem_next [`RSRT_DEPTH];
      rsrt_pkg::rsrt_word_t tap_reg, tap_next;
      rsrt_pkg::rsrt_word_t seg_in;

      // feed from the input or from the previous tap
      if (k == 0) begin : g_head
        assign seg_in = shift_word_in;
      end else begin : g_link
        assign seg_in = g_seg[k-1].tap_reg;
      end

      // read the oldest word, write the incoming one in its slot
      always_comb begin
        for (int j = 0; j < `RSRT_DEPTH; j++) begin
          mem_next[j] = mem_reg[j];
        end
        tap_next = tap_reg;
        if (shift_go) begin
          tap_next          = mem_reg[ptr_reg];
          mem_next[ptr_reg] = seg_in;
        end
      end

      // stored words clear to zero on clear or zero fill
      always_ff @(posedge clk_in or negedge mem_rst_b) begin
        if (!mem_rst_b) begin
          for (int j = 0; j < `RSRT_DEPTH; j++) begin
            mem_reg[j] <= `RSRT_WORD_ZERO;
          end
          tap_reg <= `RSRT_WORD_ZERO;
        end else begin
          for (int j = 0; j < `RSRT_DEPTH; j++) begin
            mem_reg[j] <= mem_next[j];
          end
          tap_reg <= tap_next;
        end
      end

      // pack tap words, nearest tap lowest
      assign tap_bus_out[k*`RSRT_WIDTH +: `RSRT_WIDTH] = tap_reg;
    end
  endgenerate

  // ==========================================================
  // named tap outputs
  assign first_tap_word_out  = g_seg[0].tap_reg;
  assign second_tap_word_out = g_seg[1].tap_reg;
  assign third_tap_word_out  = g_seg[2].tap_reg;
  assign fourth_tap_word_out = g_seg[3].tap_reg;
  assign chain_end_out       = g_seg[`RSRT_TAPS-1].tap_reg;

  // ==========================================================
  // displaced chain-end words
  rsrt_buf u_buf (
    .clk_in        (clk_in),
    .rst_b_in      (rst_b_in),
    .in_valid_in   (push_valid),
    .in_word_in    (g_seg[`RSRT_TAPS-1].tap_reg),
    .in_ready_out  (buf_ready),
    .out_valid_out (drain_valid_out),
    .out_word_out  (drain_word_out),
    .out_ready_in  (drain_ready_in)
  );

  assign shift_ready_out = buf_ready; // room for a displaced word

endmodule : rsrt_top

`default_nettype wire

/* tb/rsrt_top_checker.sv */
// assertions on the tapped shift register ports
`timescale 1ns/1ps
`default_nettype none
module rsrt_top_checker (
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic        clear_in,
  input wire logic        shift_en_in,
  input wire logic [7:0]  shift_word_in,
  input wire logic [7:0]  fourth_tap_word_out,
  input wire logic [7:0]  chain_end_out,
  input wire logic [31:0] tap_bus_out,
  input wire logic        shift_ready_out,
  input wire logic        drain_valid_out,
  input wire logic [7:0]  drain_word_out,
  input wire logic        drain_ready_in
);
  logic [87:0] hist_reg, hist_next;
  logic [3:0]  fill_reg, fill_next;
  logic        shift;
  logic [31:0] exp_taps;
  // words shifted since clear, newest in the low byte
  assign shift = shift_en_in && shift_ready_out;
  assign exp_taps = {hist_reg[87:80], hist_reg[63:56],
                     hist_reg[39:32], hist_reg[15:8]};
  always_comb begin
    hist_next = shift ? {hist_reg[79:0], shift_word_in} : hist_reg;
    fill_next = (shift && fill_reg != 4'hc) ? fill_reg + 4'h1 : fill_reg;
  end
  always_ff @(posedge clk_in or negedge rst_b_in or posedge clear_in) begin
    if (!rst_b_in || clear_in) begin
      hist_reg <= 88'h0;
      fill_reg <= 4'h0;
    end else begin
      hist_reg <= hist_next;
      fill_reg <= fill_next;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in || clear_in);
  end_equal_a: assert property (
    chain_end_out == fourth_tap_word_out) else $error("chain end differs");
  bus_top_a: assert property (
    tap_bus_out[31:24] == chain_end_out) else $error("bus top differs");
  taps_shift_a: assert property (
    shift |=> tap_bus_out == $past(exp_taps)) else $error("taps wrong");
  gate_hold_a: assert property (
    !shift_en_in |=> $stable(tap_bus_out)) else $error("gated taps moved");
  stall_hold_a: assert property (
    !shift_ready_out |=> $stable(tap_bus_out)) else $error("stall moved");
  clear_zero_a: assert property (disable iff (!rst_b_in)
    clear_in |-> tap_bus_out == 32'h0 && chain_end_out == 8'h00)
    else $error("clear left data");
  fresh_zero_a: assert property (
    fill_reg < 4'h3 |-> tap_bus_out == 32'h0) else $error("early tap data");
  push_word_a: assert property (
    shift && fill_reg == 4'hc && !drain_valid_out |=> drain_valid_out
    && drain_word_out == $past(fourth_tap_word_out)) else $error("no push");
  word_hold_a: assert property (
    drain_valid_out && !drain_ready_in |=> drain_valid_out
    && $stable(drain_word_out)) else $error("drain word dropped");
endmodule : rsrt_top_checker
bind rsrt_top rsrt_top_checker checker_i (.*);
`default_nettype wire

/* tb/rsrt_sink.sv */
// drain consumer model with a stall control
`timescale 1ns/1ps
`default_nettype none
module rsrt_sink (
  input  wire logic       clk_in,
  input  wire logic       stall_in,
  input  wire logic       valid_in,
  input  wire logic [7:0] word_in,
  output var logic        ready_out
);
  logic [7:0] got[$];
  initial ready_out = 1'b0;
  // take a word on valid and ready, move ready just after the edge
  always @(posedge clk_in) begin
    if (valid_in && ready_out) got.push_back(word_in);
    ready_out <= #1 !stall_in;
  end
endmodule : rsrt_sink
`default_nettype wire

/* tb/rsrt_top_tb.sv */
// self-checking bench for the tapped shift register
`timescale 1ns/1ps
`default_nettype none
module rsrt_top_tb;
  logic        clk_in = 1'b0, rst_b_in = 1'b0, clear_in = 1'b0;
  logic        shift_en_in = 1'b0, stall = 1'b1;
  logic [7:0]  shift_word_in = 8'h00, tap3, chain_end, drain_word;
  logic [7:0]  tap0, tap1, tap2;
  logic [31:0] tap_bus;
  logic        ready, drain_valid, drain_ready;
  int          err_total = 0, samples_checked = 0;
  always #50 clk_in = ~clk_in;
  // spacing is fixed at three in the design
  rsrt_top uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .clear_in(clear_in),
    .shift_en_in(shift_en_in), .shift_word_in(shift_word_in),
    .first_tap_word_out(tap0), .second_tap_word_out(tap1),
    .third_tap_word_out(tap2),
    .fourth_tap_word_out(tap3), .chain_end_out(chain_end),
    .tap_bus_out(tap_bus), .shift_ready_out(ready),
    .drain_valid_out(drain_valid), .drain_word_out(drain_word),
    .drain_ready_in(drain_ready));
  rsrt_sink sink (.clk_in(clk_in), .stall_in(stall), .valid_in(drain_valid),
    .word_in(drain_word), .ready_out(drain_ready));
  function automatic logic [7:0] wd(input int k);
    return 8'(k * 29 + 7);
  endfunction : wd
  // taps after n shifts since clear
  function automatic logic [31:0] exp_bus(input int n);
    logic [31:0] b;
    b = 32'h0;
    for (int k = 0; k < 4; k++)
      if (n - 2 - 3 * k >= 1) b[8*k +: 8] = wd(n - 2 - 3 * k);
    return b;
  endfunction : exp_bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input logic en, input logic [7:0] w);
    @(posedge clk_in);
    #1;
    shift_en_in = en;
    shift_word_in = w;
  endtask : step
  task automatic fill(input int cnt);
    logic [31:0] e;
    for (int n = 1; n <= cnt; n++) begin
      step(1'b1, wd(n));
      chk(tap_bus, exp_bus(n - 1));
    end
    step(1'b0, 8'h00);
    e = exp_bus(cnt);
    chk(tap_bus, e);
    chk({tap3, tap2, tap1, tap0}, e);
    chk(chain_end, e[31:24]);
    $display("fill test done");
  endtask : fill
  task automatic t_gate;
    repeat (3) step(1'b0, 8'hff);
    chk(tap_bus, exp_bus(12));
    $display("gate test done");
  endtask : t_gate
  task automatic t_drain;
    int n;
    n = 13;
    repeat (5) begin
      step(1'b1, wd(n));
      if (ready === 1'b1) n++;
    end
    step(1'b0, 8'h00);
    chk(n, 15);
    chk(tap_bus, exp_bus(14));
    stall = 1'b0;
    repeat (4) step(1'b0, 8'h00);
    chk(sink.got.size(), 2);
    chk(sink.got[0], wd(1));
    chk(sink.got[1], wd(2));
    chk(ready, 1'b1);
    $display("drain test done");
  endtask : t_drain
  task automatic t_clear;
    @(posedge clk_in);
    #1;
    clear_in = 1'b1;
    #1;
    chk(tap_bus, 32'h0);
    chk(chain_end, 8'h00);
    @(posedge clk_in);
    #1;
    clear_in = 1'b0;
    fill(4);
    $display("clear test done");
  endtask : t_clear
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  // main sequence after a twelve cycle reset
  initial begin
    repeat (12) @(posedge clk_in);
    #1;
    chk(tap_bus, 32'h0);
    rst_b_in = 1'b1;
    fill(12);
    t_gate;
    t_drain;
    t_clear;
    finish_test;
  end
  // watchdog well beyond the expected run
  initial begin
    #200000;
    err_total++;
    finish_test;
  end
endmodule : rsrt_top_tb
`default_nettype wire
